// ---- design/prt_check.sv ----
// decision logic of the conditional break and bound check instructions
// assumes: operands already fetched by the core; results registered by the caller
`timescale 1ns/1ps
`default_nettype none
module prt_check (
  prt_chk_if.unit chk
);
  import prt_pkg::*;

  wire is_a = chk.valid && (chk.op == OP_BREAK_A);
  wire is_b = chk.valid && (chk.op == OP_BREAK_B);
  wire is_lo = chk.valid && (chk.op == OP_LOWER);
  wire is_hi = chk.valid && (chk.op == OP_UPPER);
  // operands are never fetched here, so an illegal break operand raises nothing
  wire trap_a = is_a && chk.brk_a_en;
  wire trap_b = is_b && chk.brk_b_en;
  wire trap_lo = is_lo && ($signed(chk.source) < $signed(chk.bound));
  wire trap_hi = is_hi && ($signed(chk.source) > $signed(chk.bound));

  assign chk.trap = trap_a | trap_b | trap_lo | trap_hi;
  assign chk.code = trap_a ? TRAP_BREAK_A :
                    trap_b ? TRAP_BREAK_B :
                    trap_lo ? TRAP_LOWER :
                    trap_hi ? TRAP_UPPER : TRAP_NONE;
endmodule
`default_nettype wire

// ---- design/prt_chk_if.sv ----
// carrier between the return unit and its check-instruction decision logic
// assumes: all signals on the core clock, combinational from core side to unit side
`timescale 1ns/1ps
`default_nettype none
interface prt_chk_if;
  import prt_pkg::*;
  prt_op_t op;
  logic valid;
  logic [31:0] source;
  logic [31:0] bound;
  logic brk_a_en;
  logic brk_b_en;
  logic trap;
  prt_trap_t code;
  modport core (output op, valid, source, bound, brk_a_en, brk_b_en, input trap, code);
  modport unit (input op, valid, source, bound, brk_a_en, brk_b_en, output trap, code);
endinterface
`default_nettype wire

// ---- design/prt_pkg.sv ----
// constants, field layouts and enumerations of the procedure-return and check trap unit
// assumes: 32-bit status words, 64-bit program counter and frame pointer (object:offset)
`default_nettype none
package prt_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam int XL_W = 2;
  localparam int IRQ_W = 10;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_P_OBJ = 6'h00;
  localparam logic [ADDR_W-1:0] REG_P_OFF = 6'h04;
  localparam logic [ADDR_W-1:0] REG_Q_OBJ = 6'h08;
  localparam logic [ADDR_W-1:0] REG_Q_OFF = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_S_OFF = 6'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS_A = 6'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS_B = 6'h18;
  localparam logic [ADDR_W-1:0] REG_TRAP_INFO = 6'h1C;
  localparam logic [ADDR_W-1:0] REG_TRAP_PARAM = 6'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 6'h24;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h28;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 6'h2C;

  // procedure marker layout (bit 31 is the leftmost bit of the word)
  localparam int MARK_EXT_BIT = 31;
  localparam int MARK_ST_LSB = 24;
  localparam int MARK_ST_W = 8;
  localparam int MARK_OFF_W = 24;
  localparam int OFF_ODD_BIT = 0;

  // frame distances below the frame pointer
  localparam logic [31:0] LINK_DIST = 32'h0000_0004;
  localparam logic [31:0] MARK_DIST = 32'h0000_0008;
  localparam logic [31:0] FRAME_DIST = 32'h0000_000C;

  // status register fields
  localparam int STA_XL_LSB = 24;
  localparam int STA_SIT_BIT = 26;
  localparam int STA_DBP_BIT = 27;
  localparam int STB_BRK_A_BIT = 0;
  localparam int STB_BRK_B_BIT = 1;
  localparam int STB_XTL_LSB = 2;
  localparam int CFG_ODD_TRAP_BIT = 0;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 10'h000;

  typedef enum logic [2:0] {
    OP_RETURN = 3'h0,
    OP_BREAK_A = 3'h1,
    OP_BREAK_B = 3'h2,
    OP_LOWER = 3'h3,
    OP_UPPER = 3'h4
  } prt_op_t;

  // interrupt status bit n belongs to trap code n+1
  typedef enum logic [3:0] {
    TRAP_NONE = 4'h0,
    TRAP_CODE_RING = 4'h1,
    TRAP_MISSING_DESC = 4'h2,
    TRAP_CODE_TYPE = 4'h3,
    TRAP_EXIT_THRESH = 4'h4,
    TRAP_STACK_CONS = 4'h5,
    TRAP_ODD_PC = 4'h6,
    TRAP_BREAK_A = 4'h7,
    TRAP_BREAK_B = 4'h8,
    TRAP_LOWER = 4'h9,
    TRAP_UPPER = 4'hA
  } prt_trap_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_MARK = 3'h1,
    ST_OBJ = 3'h2,
    ST_LINK = 3'h3,
    ST_DESC = 3'h4,
    ST_DECIDE = 3'h5
  } prt_state_t;

endpackage
`default_nettype wire

// ---- design/prt_unit.sv ----
// procedure-return and check-instruction trap unit
// assumes: stack memory and descriptor lookup answer on the core clock with a valid strobe
//
// What this block does
// - top marker bit selects external return fields
// - ring trap when current level exceeds saved
// - trap missing descriptor, then non-native code type
// - exit threshold trap when saved level exceeds
// - internal return keeps object and first status
// - optional odd trap; always clear odd bit
// - commit stack, frame, counter, status after checks
// - restored single-step and debug bits act later
// - break A traps with parameter when enabled
// - break B traps with parameter when enabled
// - no operand trap for disabled breaks
// - signed lower bound check traps below bound
// - signed upper bound check traps above bound
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module prt_unit (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  // instruction command
  input wire logic CMD_VALID,
  input wire prt_pkg::prt_op_t CMD_OP,
  input wire logic [31:0] CMD_SRC,
  input wire logic [31:0] CMD_BOUND,
  output logic CMD_READY,
  output logic DONE,
  output logic TRAP,
  output prt_pkg::prt_trap_t TRAP_CODE,
  output logic [31:0] TRAP_PARAM,
  output logic SIT_ACTIVE,
  output logic DBP_ACTIVE,
  // stack memory read port
  output logic MEM_REQ,
  output logic [63:0] MEM_ADDR,
  input wire logic MEM_VALID,
  input wire logic [31:0] MEM_DATA,
  // object descriptor lookup
  output logic OD_REQ,
  output logic [31:0] OD_OBJ,
  input wire logic OD_VALID,
  input wire logic OD_EXISTS,
  input wire logic OD_NATIVE,
  // register port
  input wire logic [prt_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // interrupt
  output logic IRQ
);
  import prt_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  prt_state_t state_q, state_d;
  logic [31:0] p_obj_q, p_off_q, q_obj_q, q_off_q, s_off_q, sta_q, stb_q;
  logic [31:0] mark_q, obj_q, link_q, param_q;
  logic od_exists_q, od_native_q, cfg_odd_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
  prt_trap_t code_q;
  logic ready_q, done_q, trap_q, sit_q, dbp_q, mreq_q, odreq_q, irq_q;
  logic [63:0] maddr_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // check instructions
  prt_chk_if chk ();
  assign chk.op = CMD_OP;
  assign chk.valid = CMD_VALID && ready_q && (CMD_OP != OP_RETURN);
  assign chk.source = CMD_SRC;
  assign chk.bound = CMD_BOUND;
  assign chk.brk_a_en = stb_q[STB_BRK_A_BIT];
  assign chk.brk_b_en = stb_q[STB_BRK_B_BIT];
  prt_check u_check (
    .chk (chk.unit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // return decision
  wire start = CMD_VALID && ready_q;
  wire start_ret = start && (CMD_OP == OP_RETURN);
  wire is_ext = mark_q[MARK_EXT_BIT];
  wire [MARK_ST_W-1:0] ret_st = is_ext ? mark_q[MARK_ST_LSB +: MARK_ST_W]
                                       : sta_q[MARK_ST_LSB +: MARK_ST_W];
  wire [XL_W-1:0] ret_xl = ret_st[XL_W-1:0];
  wire [XL_W-1:0] cur_xl = sta_q[STA_XL_LSB +: XL_W];
  wire [XL_W-1:0] exit_threshold = stb_q[STB_XTL_LSB +: XL_W];
  wire [31:0] ext_off = {{(32-MARK_OFF_W){1'b0}}, mark_q[MARK_OFF_W-1:0]};
  wire [31:0] ret_off = is_ext ? ext_off : mark_q;
  wire [31:0] frame_lim = q_off_q - FRAME_DIST;
  wire bad_ring = is_ext && (cur_xl > ret_xl);
  wire bad_desc = is_ext && !od_exists_q;
  wire bad_type = is_ext && !od_native_q;
  wire bad_xtl = is_ext && (ret_xl > exit_threshold);
  wire bad_stack = $signed(link_q) < 0 || $signed(link_q) > $signed(frame_lim);
  wire bad_odd = cfg_odd_q && ret_off[OFF_ODD_BIT];
  // first failure in checking order wins
  wire prt_trap_t ret_code = bad_ring ? TRAP_CODE_RING :
                             bad_desc ? TRAP_MISSING_DESC :
                             bad_type ? TRAP_CODE_TYPE :
                             bad_xtl ? TRAP_EXIT_THRESH :
                             bad_stack ? TRAP_STACK_CONS :
                             bad_odd ? TRAP_ODD_PC : TRAP_NONE;
  wire deciding = (state_q == ST_DECIDE);
  wire commit = deciding && (ret_code == TRAP_NONE);
  wire ret_trap = deciding && (ret_code != TRAP_NONE);
  wire [31:0] clean_off = ret_off & ~(32'h0000_0001 << OFF_ODD_BIT);
  wire [31:0] new_sta = is_ext ? {ret_st, sta_q[MARK_ST_LSB-1:0]} : sta_q;
  wire [63:0] mark_addr = {q_obj_q, q_off_q - MARK_DIST};
  wire [63:0] obj_addr = {q_obj_q, q_off_q - FRAME_DIST};
  wire [63:0] link_addr = {q_obj_q, q_off_q - LINK_DIST};

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start_ret) state_d = ST_MARK;
      ST_MARK: if (MEM_VALID) state_d = MEM_DATA[MARK_EXT_BIT] ? ST_OBJ : ST_LINK;
      ST_OBJ: if (MEM_VALID) state_d = ST_LINK;
      ST_LINK: if (MEM_VALID) state_d = is_ext ? ST_DESC : ST_DECIDE;
      ST_DESC: if (OD_VALID) state_d = ST_DECIDE;
      ST_DECIDE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  wire next_mreq = (start_ret) || ((state_q == ST_MARK || state_q == ST_OBJ) && MEM_VALID);
  wire [63:0] next_maddr = start_ret ? mark_addr :
                           (state_q == ST_MARK && MEM_DATA[MARK_EXT_BIT]) ? obj_addr :
                           link_addr;
  wire next_odreq = (state_q == ST_LINK) && MEM_VALID && is_ext;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and outputs
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      trap_q <= 1'b0;
      code_q <= TRAP_NONE;
      param_q <= RST_WORD;
      mreq_q <= 1'b0;
      maddr_q <= {RST_WORD, RST_WORD};
      odreq_q <= 1'b0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      ready_q <= (state_d == ST_IDLE);
      done_q <= commit || (chk.valid && !chk.trap);
      trap_q <= ret_trap || chk.trap;
      mreq_q <= next_mreq;
      odreq_q <= next_odreq;
      if (next_mreq) maddr_q <= next_maddr;
      if (ret_trap) code_q <= ret_code;
      else if (chk.trap) code_q <= chk.code;
      if (ret_trap) param_q <= ret_off;
      else if (chk.trap) param_q <= CMD_SRC;
    end
  end

  // marker words and descriptor answers
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mark_q <= RST_WORD;
      obj_q <= RST_WORD;
      link_q <= RST_WORD;
      od_exists_q <= 1'b0;
      od_native_q <= 1'b0;
    end else if (CLK_EN) begin
      if (state_q == ST_MARK && MEM_VALID) mark_q <= MEM_DATA;
      if (state_q == ST_OBJ && MEM_VALID) obj_q <= MEM_DATA;
      if (state_q == ST_LINK && MEM_VALID) link_q <= MEM_DATA;
      if (state_q == ST_DESC && OD_VALID) begin
        od_exists_q <= OD_EXISTS;
        od_native_q <= OD_NATIVE;
      end
    end
  end

  // restored step and debug bits only reach the core at the next instruction start
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sit_q <= 1'b0;
      dbp_q <= 1'b0;
    end else if (CLK_EN && start) begin
      sit_q <= sta_q[STA_SIT_BIT];
      dbp_q <= sta_q[STA_DBP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural registers; the return commit takes priority over software writes
  wire wr_p_obj = REG_WR && hit(REG_ADDR, REG_P_OBJ);
  wire wr_p_off = REG_WR && hit(REG_ADDR, REG_P_OFF);
  wire wr_q_obj = REG_WR && hit(REG_ADDR, REG_Q_OBJ);
  wire wr_q_off = REG_WR && hit(REG_ADDR, REG_Q_OFF);
  wire wr_s_off = REG_WR && hit(REG_ADDR, REG_S_OFF);
  wire wr_sta = REG_WR && hit(REG_ADDR, REG_STATUS_A);
  wire wr_stb = REG_WR && hit(REG_ADDR, REG_STATUS_B);
  wire wr_mask = REG_WR && hit(REG_ADDR, REG_IRQ_MASK);
  wire wr_cfg = REG_WR && hit(REG_ADDR, REG_CONFIG);

  // a trap reaches none of these, so the caller's context stays intact
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p_obj_q <= RST_WORD;
      p_off_q <= RST_WORD;
      q_obj_q <= RST_WORD;
      q_off_q <= RST_WORD;
      s_off_q <= RST_WORD;
      sta_q <= RST_WORD;
      stb_q <= RST_WORD;
      cfg_odd_q <= 1'b0;
      irq_mask_q <= RST_IRQ;
    end else if (CLK_EN) begin
      if (commit) begin
        if (is_ext) p_obj_q <= obj_q;
        p_off_q <= clean_off;
        q_off_q <= link_q;
        s_off_q <= frame_lim;
        sta_q <= new_sta;
      end else begin
        if (wr_p_obj) p_obj_q <= REG_WDATA;
        if (wr_p_off) p_off_q <= REG_WDATA;
        if (wr_q_off) q_off_q <= REG_WDATA;
        if (wr_s_off) s_off_q <= REG_WDATA;
        if (wr_sta) sta_q <= REG_WDATA;
      end
      if (wr_q_obj) q_obj_q <= REG_WDATA;
      if (wr_stb) stb_q <= REG_WDATA;
      if (wr_cfg) cfg_odd_q <= REG_WDATA[CFG_ODD_TRAP_BIT];
      if (wr_mask) irq_mask_q <= REG_WDATA[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky trap status, cleared by reading it; a new trap wins over the clear
  wire rd_stat = REG_RD && hit(REG_ADDR, REG_IRQ_STATUS);
  wire trap_now = ret_trap || chk.trap;
  wire prt_trap_t code_now = ret_trap ? ret_code : chk.code;
  logic [IRQ_W-1:0] irq_set;
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : g_irq
      assign irq_set[gi] = trap_now && (code_now == prt_trap_t'(gi + 1));
    end
  endgenerate
  wire [IRQ_W-1:0] irq_stat_d = (rd_stat ? RST_IRQ : irq_stat_q) | irq_set;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_q <= RST_IRQ;
      irq_q <= 1'b0;
    end else if (CLK_EN) begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  wire [31:0] trap_info = {{(32-5){1'b0}}, !ready_q, code_q};
  wire [31:0] rd_mux = hit(REG_ADDR, REG_P_OBJ) ? p_obj_q :
                       hit(REG_ADDR, REG_P_OFF) ? p_off_q :
                       hit(REG_ADDR, REG_Q_OBJ) ? q_obj_q :
                       hit(REG_ADDR, REG_Q_OFF) ? q_off_q :
                       hit(REG_ADDR, REG_S_OFF) ? s_off_q :
                       hit(REG_ADDR, REG_STATUS_A) ? sta_q :
                       hit(REG_ADDR, REG_STATUS_B) ? stb_q :
                       hit(REG_ADDR, REG_TRAP_INFO) ? trap_info :
                       hit(REG_ADDR, REG_TRAP_PARAM) ? param_q :
                       hit(REG_ADDR, REG_IRQ_STATUS) ? {{(32-IRQ_W){1'b0}}, irq_stat_q} :
                       hit(REG_ADDR, REG_IRQ_MASK) ? {{(32-IRQ_W){1'b0}}, irq_mask_q} :
                       hit(REG_ADDR, REG_CONFIG) ? {{31{1'b0}}, cfg_odd_q} : RST_WORD;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= RST_WORD;
    end else if (CLK_EN) begin
      rdata_q <= REG_RD ? rd_mux : RST_WORD;
    end
  end

  assign CMD_READY = ready_q;
  assign DONE = done_q;
  assign TRAP = trap_q;
  assign TRAP_CODE = code_q;
  assign TRAP_PARAM = param_q;
  assign SIT_ACTIVE = sit_q;
  assign DBP_ACTIVE = dbp_q;
  assign MEM_REQ = mreq_q;
  assign MEM_ADDR = maddr_q;
  assign OD_REQ = odreq_q;
  assign OD_OBJ = obj_q;
  assign REG_RDATA = rdata_q;
  assign IRQ = irq_q;
endmodule
`default_nettype wire

// ---- test/prt_stack_mem.sv ----
// stack memory and descriptor lookup model beside the return unit
// assumes: one answer per request, stack reads lat cycles after it, descriptor lookups one cycle after it, lat at least 1
`timescale 1ns/1ps
`default_nettype none
module prt_stack_mem (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // stack reads
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  output logic mem_valid,
  output logic [31:0] mem_data,
  // descriptor lookup
  input wire logic od_req,
  output logic od_valid,
  output logic od_exists,
  output logic od_native,
  // scenario controls
  input wire logic [3:0] lat,
  input wire logic desc_exists,
  input wire logic desc_native
);
  logic [31:0] words [logic [63:0]];
  logic [63:0] addr_q;
  logic [3:0] cnt_q;
  wire [63:0] addr = mem_req ? mem_addr : addr_q;
  wire answer = mem_req ? (lat <= 4'h1) : (cnt_q == 4'h1);
  ////////////////////////////////////////////////////////////////
  // released lines toggle every cycle so stale data never looks valid
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_valid <= 1'b0;
      mem_data <= 32'h0;
      cnt_q <= 4'h0;
      od_valid <= 1'b0;
    end else begin
      mem_valid <= answer;
      mem_data <= answer ? words[addr] : ~mem_data;
      addr_q <= addr;
      cnt_q <= mem_req ? lat - 4'h1 : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      od_valid <= od_req;
      od_exists <= od_req ? desc_exists : ~od_exists;
      od_native <= od_req ? desc_native : ~od_native;
    end
  end
endmodule
`default_nettype wire

// ---- test/prt_unit_props.sv ----
// port-level checks of the return and check trap unit
// assumes: bound into prt_unit, clock enable held high
`timescale 1ns/1ps
`default_nettype none
module prt_unit_props (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // command and result
  input wire logic CMD_VALID,
  input wire prt_pkg::prt_op_t CMD_OP,
  input wire logic [31:0] CMD_SRC,
  input wire logic [31:0] CMD_BOUND,
  input wire logic CMD_READY,
  input wire logic DONE,
  input wire logic TRAP,
  input wire prt_pkg::prt_trap_t TRAP_CODE,
  input wire logic [31:0] TRAP_PARAM,
  input wire logic SIT_ACTIVE,
  input wire logic DBP_ACTIVE
);
  import prt_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  wire go = CMD_VALID && CMD_READY;
  wire go_ret = go && CMD_OP == OP_RETURN;
  ////////////////////////////////////////////////////////////////
  property p_chk_answer;
    go && !go_ret |=> (DONE != TRAP) && CMD_READY;
  endproperty
  a_chk_answer: assert property (p_chk_answer) else $error("check op answer wrong");
  property p_lower;
    go && CMD_OP == OP_LOWER |=> TRAP == ($signed($past(CMD_SRC)) < $signed($past(CMD_BOUND)));
  endproperty
  a_lower: assert property (p_lower) else $error("lower bound decision wrong");
  property p_upper;
    go && CMD_OP == OP_UPPER |=> TRAP == ($signed($past(CMD_SRC)) > $signed($past(CMD_BOUND)));
  endproperty
  a_upper: assert property (p_upper) else $error("upper bound decision wrong");
  property p_brk_a;
    go && CMD_OP == OP_BREAK_A ##1 TRAP |->
      TRAP_CODE == TRAP_BREAK_A && TRAP_PARAM == $past(CMD_SRC);
  endproperty
  a_brk_a: assert property (p_brk_a) else $error("break A trap content wrong");
  property p_brk_b;
    go && CMD_OP == OP_BREAK_B ##1 TRAP |->
      TRAP_CODE == TRAP_BREAK_B && TRAP_PARAM == $past(CMD_SRC);
  endproperty
  a_brk_b: assert property (p_brk_b) else $error("break B trap content wrong");
  property p_ret_busy;
    go_ret |=> (!CMD_READY && !DONE && !TRAP) [*4];
  endproperty
  a_ret_busy: assert property (p_ret_busy) else $error("return finished too early");
  property p_ret_ends;
    go_ret |=> ##[4:120] (DONE || TRAP);
  endproperty
  a_ret_ends: assert property (p_ret_ends) else $error("return never finished");
  property p_status_hold;
    !$past(go) |-> $stable(SIT_ACTIVE) && $stable(DBP_ACTIVE);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("step bits moved");
endmodule
bind prt_unit prt_unit_props prt_unit_props_i (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_SRC(CMD_SRC),
  .CMD_BOUND(CMD_BOUND), .CMD_READY(CMD_READY), .DONE(DONE), .TRAP(TRAP),
  .TRAP_CODE(TRAP_CODE), .TRAP_PARAM(TRAP_PARAM), .SIT_ACTIVE(SIT_ACTIVE),
  .DBP_ACTIVE(DBP_ACTIVE)
);
`default_nettype wire

// ---- test/tb_procedure_return_and_check_traps.sv ----
// self-checking bench of the return and check trap unit
// assumes: stack model answers every read; clock enable held high
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_procedure_return_and_check_traps;
  import prt_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  prt_op_t cmd_op = OP_RETURN;
  logic [31:0] cmd_src = 32'h0;
  logic [31:0] cmd_bound = 32'h0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] lat = 4'h1;
  logic dex = 1'b1;
  logic dnat = 1'b1;
  logic cmd_ready, done, trap, single_instruction_trap_bit, debug_pending_bit, mem_req, mem_valid, od_req, od_valid, od_ex, od_nat, irq;
  prt_trap_t trap_code;
  logic [31:0] trap_param, mem_data, od_obj, reg_rdata, s, b, d;
  logic [63:0] mem_addr;
  int n_mismatch = 0;
  int compares = 0;
  always #2 clk = ~clk;
  prt_unit prt_unit_i (
    .SYS_CLK(clk), .RSTN(rstn), .CLK_EN(1'b1), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_SRC(cmd_src), .CMD_BOUND(cmd_bound), .CMD_READY(cmd_ready), .DONE(done), .TRAP(trap),
    .TRAP_CODE(trap_code), .TRAP_PARAM(trap_param), .SIT_ACTIVE(single_instruction_trap_bit), .DBP_ACTIVE(debug_pending_bit),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_VALID(mem_valid), .MEM_DATA(mem_data),
    .OD_REQ(od_req), .OD_OBJ(od_obj), .OD_VALID(od_valid), .OD_EXISTS(od_ex), .OD_NATIVE(od_nat),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .IRQ(irq)
  );
  prt_stack_mem prt_stack_mem_i (
    .clk(clk), .rstn(rstn), .mem_req(mem_req), .mem_addr(mem_addr), .mem_valid(mem_valid),
    .mem_data(mem_data), .od_req(od_req), .od_valid(od_valid), .od_exists(od_ex),
    .od_native(od_nat), .lat(lat), .desc_exists(dex), .desc_native(dnat)
  );
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick(1);
    reg_rd <= 1'b0;
    d = reg_rdata;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask
  // waits for the unit's own completion pulse, bounded
  task automatic run(input prt_op_t op, input logic [31:0] sv, input logic [31:0] bv);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_src <= sv;
    cmd_bound <= bv;
    tick(1);
    cmd_valid <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1 && trap !== 1'b1; i++) tick(1);
    if (i == 200) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic res(input logic t, input prt_trap_t c, input logic [31:0] p);
    `CHK({done, trap}, {~t, t})
    if (t) `CHK(trap_code, c)
    if (t) `CHK(trap_param, p)
  endtask
  // frame pointer 0x100: marker at 0xF8, object word at 0xF4, saved frame at 0xFC
  task automatic ret_case(input logic [31:0] mk, lk, sa, sb, input logic [2:0] f,
                          input prt_trap_t c);
    logic ok, ext;
    ok = c == TRAP_NONE;
    ext = mk[31];
    prt_stack_mem_i.words[64'hF4] = 32'h55;
    prt_stack_mem_i.words[64'hF8] = mk;
    prt_stack_mem_i.words[64'hFC] = lk;
    dex <= f[1];
    dnat <= f[0];
    lat <= lat ^ 4'h2;
    wr(REG_Q_OFF, 32'h100);
    wr(REG_S_OFF, 32'h33);
    wr(REG_P_OBJ, 32'h77);
    wr(REG_P_OFF, 32'h9);
    wr(REG_STATUS_A, sa);
    wr(REG_STATUS_B, sb);
    wr(REG_CONFIG, {31'h0, f[2]});
    run(OP_RETURN, 32'h0, 32'h0);
    res(!ok, c, ext ? {8'h0, mk[23:0]} : mk);
    rdc(REG_P_OBJ, ok && ext ? 32'h55 : 32'h77);
    rdc(REG_P_OFF, !ok ? 32'h9 : ext ? {8'h0, mk[23:1], 1'b0} : {mk[31:1], 1'b0});
    rdc(REG_Q_OFF, ok ? lk : 32'h100);
    rdc(REG_S_OFF, ok ? 32'hF4 : 32'h33);
    rdc(REG_STATUS_A, ok && ext ? {mk[31:24], sa[23:0]} : sa);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(31));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    for (int a = 0; a < 13; a++) rdc(6'(4 * a), 32'h0);
    wr(REG_IRQ_MASK, 32'h3FF);
    for (int k = 0; k < 24; k++) begin
      b = $urandom;
      s = (k % 3 == 0) ? b : (k % 3 == 1) ? b ^ 32'h8000_0000 : $urandom;
      run(k % 2 ? OP_UPPER : OP_LOWER, s, b);
      if (k % 2) res($signed(s) > $signed(b), TRAP_UPPER, s);
      else res($signed(s) < $signed(b), TRAP_LOWER, s);
    end
    for (int e = 0; e < 4; e++) begin
      wr(REG_STATUS_B, 32'(e));
      s = $urandom;
      run(OP_BREAK_A, s, 32'h0);
      res(e % 2, TRAP_BREAK_A, s);
      run(OP_BREAK_B, s, 32'h0);
      res(e / 2, TRAP_BREAK_B, s);
    end
    rd(REG_IRQ_STATUS);
    tick(1);
    `CHK(irq, 1'b0)
    run(OP_LOWER, 32'hFFFF_FFFB, 32'h0);
    res(1'b1, TRAP_LOWER, 32'hFFFF_FFFB);
    tick(1);
    `CHK(irq, 1'b1)
    rdc(REG_IRQ_STATUS, 32'h100);
    tick(1);
    `CHK(irq, 1'b0)
    wr(REG_IRQ_MASK, 32'h0);
    run(OP_UPPER, 32'h1, 32'h0);
    res(1'b1, TRAP_UPPER, 32'h1);
    tick(2);
    `CHK(irq, 1'b0)
    wr(REG_IRQ_MASK, 32'h3FF);
    tick(1);
    `CHK(irq, 1'b1)
    rdc(REG_IRQ_STATUS, 32'h200);
    ret_case(32'h1235, 32'hF4, 32'h0100_00A5, 32'h0, 3'b011, TRAP_NONE);
    ret_case(32'h1235, 32'h40, 32'h0, 32'h0, 3'b111, TRAP_ODD_PC);
    ret_case(32'h1234, 32'hF5, 32'h0, 32'h0, 3'b011, TRAP_STACK_CONS);
    ret_case(32'h1234, 32'hFFFF_FFF0, 32'h0, 32'h0, 3'b011, TRAP_STACK_CONS);
    ret_case(32'h8100_0010, 32'h80, 32'h0200_0000, 32'h0, 3'b001, TRAP_CODE_RING);
    ret_case(32'h8100_0010, 32'h80, 32'h0, 32'hC, 3'b001, TRAP_MISSING_DESC);
    ret_case(32'h8100_0010, 32'h80, 32'h0, 32'hC, 3'b010, TRAP_CODE_TYPE);
    ret_case(32'h8200_0010, 32'h80, 32'h0, 32'h4, 3'b011, TRAP_EXIT_THRESH);
    ret_case(32'h8F12_3457, 32'h80, 32'h0, 32'hC, 3'b011, TRAP_NONE);
    `CHK({single_instruction_trap_bit, debug_pending_bit}, 2'b00)
    run(OP_LOWER, 32'h0, 32'h0);
    `CHK({single_instruction_trap_bit, debug_pending_bit}, 2'b11)
    tally_and_finish();
  end
endmodule
`default_nettype wire
